// ==== common/fbp_pkg.sv ====
package fbp_pkg;

   // ----------------------------------------------------------------
   // Register map, byte addresses
   // ----------------------------------------------------------------
   localparam logic [15:0] FBP_CTRL_OFS  = 16'h0000;
   localparam logic [15:0] FBP_TGT_OFS   = 16'h0004;
   localparam logic [15:0] FBP_STAT_OFS  = 16'h0008;
   localparam logic [15:0] FBP_PROT_OFS  = 16'hff80;

   // ----------------------------------------------------------------
   // Control register fields
   // ----------------------------------------------------------------
   localparam int          FBP_PGM_BIT   = 0;
   localparam int          FBP_ERASE_BIT = 1;
   localparam int          FBP_HV_BIT    = 3;

   // ----------------------------------------------------------------
   // Status register fields
   // ----------------------------------------------------------------
   localparam int          FBP_ST_LATCH_BIT = 0;
   localparam int          FBP_ST_PUMP_BIT  = 1;
   localparam int          FBP_ST_STBY_BIT  = 2;
   localparam int          FBP_ST_TVOLT_BIT = 3;

   // ----------------------------------------------------------------
   // Protected ranges, one per protect bit, all ending at the top
   // ----------------------------------------------------------------
   localparam int          FBP_NPROT       = 4;
   localparam logic [15:0] FBP_RANGE_TOP   = 16'hffff;
   localparam logic [3:0][15:0] FBP_RANGE_BASE = {16'hf000, 16'he000, 16'hc000, 16'ha000};
   localparam logic [7:0]  FBP_PROT_FACTORY = 8'h00;

   // ----------------------------------------------------------------
   // Bus answers
   // ----------------------------------------------------------------
   localparam logic [1:0]  FBP_RESP_OKAY   = 2'b00;
   localparam logic [1:0]  FBP_RESP_SLVERR = 2'b10;

   typedef struct packed {
      logic [7:0]  prot_byte;
      logic [7:0]  latched;
      logic        latched_valid;
      logic        program_select;
      logic        erase;
      logic        hv;
      logic        pump;
      logic        standby;
      logic [15:0] target;
      logic        aw_full;
      logic [15:0] awaddr;
      logic        w_full;
      logic [15:0] wdata;
      logic [1:0]  wstrb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } fbp_state_t;

   localparam fbp_state_t FBP_STATE_RESET = '0;

endpackage

// ==== verilog/fbp_range_chk.sv ====
`timescale 1ns/100ps
module fbp_range_chk #(
   parameter logic [15:0] BASE = 16'h0000,
   parameter logic [15:0] TOP  = 16'hffff
) (
   input  wire logic        en,
   input  wire logic [15:0] addr,
   output logic             hit
);
   assign hit = en && (addr >= BASE) && (addr <= TOP);
endmodule // fbp_range_chk

// ==== verilog/fbp_flash_protect.sv ====
`timescale 1ns/100ps
// Overview of operation
// - Reading the protect byte copies it into the controller.
// - A target inside a protected block clears program and erase select.
// - High voltage enable needs a protect byte read in this operation.
// - All protect bits zero leaves the whole array open.
// - Protect bit 3 locks F000 to FFFF.
// - Protect bit 2 locks E000 to FFFF.
// - Protect bit 1 locks C000 to FFFF.
// - Protect bit 0 locks A000 to FFFF.
// - Protect byte survives reset; factory value zero; top four bits reserved.
// - Several set bits lock the union of their ranges.
// - Test voltage on the interrupt pin bypasses all protection.
// - Wait in read mode changes nothing in the flash.
// - Wait turns the charge pump off.
// - Select and voltage enable stay unchanged during wait while both are set.
// - Stop in read mode puts the array in standby.
// - Stop turns the charge pump off.
// - Select and voltage enable stay unchanged during stop while both are set.
// - An erase target in a protected area clears erase select.
// - Voltage enable accepts a one only while a select bit is set.
module fbp_flash_protect (
   input  wire logic        MCLK,
   input  wire logic        SRST,
   input  wire logic [15:0] AWADDR,
   input  wire logic [2:0]  AWPROT,
   input  wire logic        AWVALID,
   output logic             AWREADY,
   input  wire logic [31:0] WDATA,
   input  wire logic [3:0]  WSTRB,
   input  wire logic        WVALID,
   output logic             WREADY,
   output logic [1:0]       BRESP,
   output logic             BVALID,
   input  wire logic        BREADY,
   input  wire logic [15:0] ARADDR,
   input  wire logic [2:0]  ARPROT,
   input  wire logic        ARVALID,
   output logic             ARREADY,
   output logic [31:0]      RDATA,
   output logic [1:0]       RRESP,
   output logic             RVALID,
   input  wire logic        RREADY,
   input  wire logic        TEST_VOLTAGE_LEVEL,
   input  wire logic        WAIT_MODE,
   input  wire logic        STOP_MODE,
   output logic             HIGH_VOLTAGE_ENABLE,
   output logic             CHARGE_PUMP_ON,
   output logic             ARRAY_STANDBY
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   // Protect byte models a flash cell: power-up value is the factory
   // value and reset never touches it.
   fbp_pkg::fbp_state_t state_reg = fbp_pkg::FBP_STATE_RESET;
   fbp_pkg::fbp_state_t state_next;

   logic [15:0]                     chk_addr;
   logic [fbp_pkg::FBP_NPROT-1:0]   hits;
   logic                            blocked;
   logic                            frozen;
   logic                            do_write;
   logic                            rd_take;
   logic                            op_sel;
   logic [31:0]                     stat_word;

   // ----------------------------------------------------------------
   // Range check against the latched copy
   // ----------------------------------------------------------------
   assign chk_addr = (state_reg.awaddr == fbp_pkg::FBP_PROT_OFS) ?
                     fbp_pkg::FBP_PROT_OFS : state_reg.wdata;

   genvar gi;
   generate
      for (gi = 0; gi < fbp_pkg::FBP_NPROT; gi++) begin : g_rng
         fbp_range_chk #(
            .BASE (fbp_pkg::FBP_RANGE_BASE[gi]),
            .TOP  (fbp_pkg::FBP_RANGE_TOP)
         ) u_chk (
            .en   (state_reg.latched[gi]),
            .addr (chk_addr),
            .hit  (hits[gi])
         );
      end
   endgenerate

   assign blocked  = (|hits) && !TEST_VOLTAGE_LEVEL;
   assign op_sel   = state_reg.program_select || state_reg.erase;
   assign frozen   = (WAIT_MODE || STOP_MODE) && op_sel && state_reg.hv;
   assign do_write = state_reg.aw_full && state_reg.w_full;
   assign rd_take  = ARVALID && ARREADY;

   // ----------------------------------------------------------------
   // Bus handshakes
   // ----------------------------------------------------------------
   assign AWREADY  = !state_reg.aw_full && !state_reg.bvalid;
   assign WREADY   = !state_reg.w_full && !state_reg.bvalid;
   assign ARREADY  = !state_reg.rvalid;
   assign BVALID   = state_reg.bvalid;
   assign BRESP    = state_reg.bresp;
   assign RVALID   = state_reg.rvalid;
   assign RDATA    = state_reg.rdata;
   assign RRESP    = state_reg.rresp;

   assign HIGH_VOLTAGE_ENABLE = state_reg.hv;
   assign CHARGE_PUMP_ON      = state_reg.pump;
   assign ARRAY_STANDBY       = state_reg.standby;

   always_comb begin
      stat_word = 32'h0000_0000;
      stat_word[fbp_pkg::FBP_ST_LATCH_BIT] = state_reg.latched_valid;
      stat_word[fbp_pkg::FBP_ST_PUMP_BIT]  = state_reg.pump;
      stat_word[fbp_pkg::FBP_ST_STBY_BIT]  = state_reg.standby;
      stat_word[fbp_pkg::FBP_ST_TVOLT_BIT] = TEST_VOLTAGE_LEVEL;
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;

      if (AWVALID && AWREADY) begin
         state_next.aw_full = 1'b1;
         state_next.awaddr  = AWADDR;
      end
      if (WVALID && WREADY) begin
         state_next.w_full = 1'b1;
         state_next.wdata  = WDATA[15:0];
         state_next.wstrb  = WSTRB[1:0];
      end
      if (state_reg.bvalid && BREADY) begin
         state_next.bvalid = 1'b0;
      end

      if (do_write) begin
         state_next.aw_full = 1'b0;
         state_next.w_full  = 1'b0;
         state_next.bvalid  = 1'b1;
         state_next.bresp   = fbp_pkg::FBP_RESP_OKAY;
         case (state_reg.awaddr)
            fbp_pkg::FBP_CTRL_OFS: begin
               // Writes are ignored while a held operation sits in wait or stop
               if (state_reg.wstrb[0] && !frozen) begin
                  // Interlock: asking for both selects changes neither
                  if (!(state_reg.wdata[fbp_pkg::FBP_PGM_BIT] &&
                        state_reg.wdata[fbp_pkg::FBP_ERASE_BIT])) begin
                     state_next.program_select   = state_reg.wdata[fbp_pkg::FBP_PGM_BIT];
                     state_next.erase = state_reg.wdata[fbp_pkg::FBP_ERASE_BIT];
                  end
                  if (!state_reg.wdata[fbp_pkg::FBP_HV_BIT]) begin
                     state_next.hv = 1'b0;
                  end else if ((state_next.program_select || state_next.erase) &&
                               state_reg.latched_valid) begin
                     state_next.hv = 1'b1;
                  end
               end
            end
            fbp_pkg::FBP_TGT_OFS: begin
               if ((&state_reg.wstrb) && !frozen) begin
                  state_next.target = state_reg.wdata;
                  if (op_sel && blocked) begin
                     state_next.program_select   = 1'b0;
                     state_next.erase = 1'b0;
                  end
               end
            end
            fbp_pkg::FBP_PROT_OFS: begin
               // Only a live, unprotected program or erase pulse alters the cell
               if (state_reg.wstrb[0] && state_reg.pump && !blocked) begin
                  if (state_reg.program_select) begin
                     state_next.prot_byte = state_reg.prot_byte | state_reg.wdata[7:0];
                  end else if (state_reg.erase) begin
                     state_next.prot_byte = fbp_pkg::FBP_PROT_FACTORY;
                  end
               end
            end
            fbp_pkg::FBP_STAT_OFS: begin
            end
            default: begin
               state_next.bresp = fbp_pkg::FBP_RESP_SLVERR;
            end
         endcase
      end

      // Leaving program and erase ends the operation and its latch
      if (!(state_next.program_select || state_next.erase)) begin
         state_next.hv            = 1'b0;
         state_next.latched_valid = 1'b0;
      end

      if (state_reg.rvalid && RREADY) begin
         state_next.rvalid = 1'b0;
      end
      if (rd_take) begin
         state_next.rvalid = 1'b1;
         state_next.rresp  = fbp_pkg::FBP_RESP_OKAY;
         state_next.rdata  = 32'h0000_0000;
         case (ARADDR)
            fbp_pkg::FBP_CTRL_OFS: begin
               state_next.rdata[fbp_pkg::FBP_PGM_BIT]   = state_reg.program_select;
               state_next.rdata[fbp_pkg::FBP_ERASE_BIT] = state_reg.erase;
               state_next.rdata[fbp_pkg::FBP_HV_BIT]    = state_reg.hv;
            end
            fbp_pkg::FBP_TGT_OFS: begin
               state_next.rdata[15:0] = state_reg.target;
            end
            fbp_pkg::FBP_STAT_OFS: begin
               state_next.rdata = stat_word;
            end
            fbp_pkg::FBP_PROT_OFS: begin
               state_next.rdata[7:0] = state_reg.prot_byte;
               state_next.latched    = state_reg.prot_byte;
               // Only counts for the voltage step once an operation is selected
               state_next.latched_valid = state_next.program_select || state_next.erase;
            end
            default: begin
               state_next.rresp = fbp_pkg::FBP_RESP_SLVERR;
            end
         endcase
      end

      // Pump follows the enable but goes off one cycle after wait or stop is seen
      state_next.pump    = state_next.hv && !WAIT_MODE && !STOP_MODE;
      state_next.standby = STOP_MODE &&
                           !(state_next.program_select || state_next.erase || state_next.hv);

      if (SRST) begin
         state_next           = fbp_pkg::FBP_STATE_RESET;
         state_next.prot_byte = state_reg.prot_byte;
      end
   end

   always_ff @(posedge MCLK) begin
      state_reg <= state_next;
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (SRST);

   sequence s_prot_read;
      rd_take && (ARADDR == fbp_pkg::FBP_PROT_OFS);
   endsequence

   sequence s_tgt_write;
      do_write && (state_reg.awaddr == fbp_pkg::FBP_TGT_OFS) && (&state_reg.wstrb) && !frozen;
   endsequence

   property p_latch_on_read;
      s_prot_read |=> (state_reg.latched == $past(state_reg.prot_byte)) &&
                      (RDATA[7:0] == $past(state_reg.prot_byte)) && RVALID;
   endproperty
   a_latch_on_read: assert property (p_latch_on_read)
      else $error("protect byte not latched");

   property p_block_clears;
      (s_tgt_write and (op_sel && blocked))
         |=> !state_reg.program_select && !state_reg.erase && !HIGH_VOLTAGE_ENABLE;
   endproperty
   a_block_clears: assert property (p_block_clears)
      else $error("protected target kept select");

   property p_hv_needs_latch;
      $rose(HIGH_VOLTAGE_ENABLE) |-> $past(state_reg.latched_valid);
   endproperty
   a_hv_needs_latch: assert property (p_hv_needs_latch)
      else $error("voltage set without latch");

   property p_hv_needs_sel;
      $rose(HIGH_VOLTAGE_ENABLE) |-> (state_reg.program_select || state_reg.erase) && $past(op_sel || do_write);
   endproperty
   a_hv_needs_sel: assert property (p_hv_needs_sel)
      else $error("voltage set without select");

   property p_open_array;
      (s_tgt_write and (state_reg.latched[3:0] == 4'h0) and (op_sel && !state_reg.hv))
         |=> (state_reg.program_select == $past(state_reg.program_select)) && (state_reg.erase == $past(state_reg.erase));
   endproperty
   a_open_array: assert property (p_open_array) else $error("open array refused");

   property p_ranges;
      (blocked == ((|(state_reg.latched[3:0] & {chk_addr >= 16'hf000, chk_addr >= 16'he000,
                    chk_addr >= 16'hc000, chk_addr >= 16'ha000})) && !TEST_VOLTAGE_LEVEL));
   endproperty
   a_ranges: assert property (p_ranges)
      else $error("range decode wrong");

   property p_pump_off;
      (WAIT_MODE || STOP_MODE) [*2] |-> !CHARGE_PUMP_ON;
   endproperty
   a_pump_off: assert property (p_pump_off) else $error("pump on in low power");

   property p_hold_mode;
      frozen |=> $stable(state_reg.program_select) && $stable(state_reg.erase) && $stable(HIGH_VOLTAGE_ENABLE);
   endproperty
   a_hold_mode: assert property (p_hold_mode)
      else $error("mode changed in low power");

   property p_standby;
      (STOP_MODE && !op_sel && !state_reg.hv && !do_write) |=> ARRAY_STANDBY;
   endproperty
   a_standby: assert property (p_standby) else $error("no standby in stop");

   property p_prot_kept;
      !do_write |=> $stable(state_reg.prot_byte);
   endproperty
   a_prot_kept: assert property (p_prot_kept) else $error("protect byte changed");

   sequence s_prot_pulse;
      do_write && (state_reg.awaddr == fbp_pkg::FBP_PROT_OFS) && state_reg.wstrb[0];
   endsequence

   property p_prot_wr_blocked;
      (s_prot_pulse and blocked) |=> $stable(state_reg.prot_byte);
   endproperty
   a_prot_wr_blocked: assert property (p_prot_wr_blocked)
      else $error("protected cell altered");

   property p_test_bypass;
      (s_tgt_write and (op_sel && TEST_VOLTAGE_LEVEL)) |=> (state_reg.program_select || state_reg.erase);
   endproperty
   a_test_bypass: assert property (p_test_bypass)
      else $error("test voltage did not bypass protection");

   property p_wait_read;
      (WAIT_MODE && !STOP_MODE) |=> !ARRAY_STANDBY;
   endproperty
   a_wait_read: assert property (p_wait_read)
      else $error("wait changed read mode");

   // Reset must never touch the cell, so this check stays live through it
   property p_reset_keeps;
      disable iff (1'b0)
      SRST |=> $stable(state_reg.prot_byte) && !state_reg.latched_valid && !HIGH_VOLTAGE_ENABLE;
   endproperty
   a_reset_keeps: assert property (p_reset_keeps)
      else $error("reset altered protect state");

   property p_hv_drops;
      !op_sel |-> !HIGH_VOLTAGE_ENABLE && !state_reg.latched_valid;
   endproperty
   a_hv_drops: assert property (p_hv_drops)
      else $error("voltage or latch kept without select");

endmodule // fbp_flash_protect

// ==== verification/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
   logic        MCLK = 1'b0;
   logic        SRST = 1'b1;
   logic [15:0] AWADDR = 16'h0000;
   logic [15:0] ARADDR = 16'h0000;
   logic [31:0] WDATA = 32'h0000_0000;
   logic [3:0]  WSTRB = 4'h0;
   logic        AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
   logic        TEST_VOLTAGE_LEVEL = 1'b0, WAIT_MODE = 1'b0, STOP_MODE = 1'b0;
   logic        AWREADY, WREADY, BVALID, ARREADY, RVALID;
   logic        HIGH_VOLTAGE_ENABLE, CHARGE_PUMP_ON, ARRAY_STANDBY;
   logic [1:0]  BRESP, RRESP;
   logic [31:0] RDATA;
   int          mismatches = 0;
   int          n_compared = 0;
   logic [1:0]  q_b[$];
   logic [65:0] q_r[$];
   logic [7:0]  prot_m = 8'h00;
   logic [7:0]  pats[7] = '{8'h00, 8'h08, 8'h04, 8'h02, 8'h01, 8'h0c, 8'h03};
   logic [15:0] adrs[8] = '{16'ha000, 16'hbfff, 16'hc000, 16'hdfff, 16'he000, 16'hefff,
                            16'hf000, 16'hffff};
   localparam logic [1:0] OK = fbp_pkg::FBP_RESP_OKAY;

   fbp_flash_protect i_dut (
      .MCLK(MCLK), .SRST(SRST), .AWADDR(AWADDR), .AWPROT(3'b000), .AWVALID(AWVALID),
      .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
      .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARPROT(3'b000),
      .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
      .RREADY(RREADY), .TEST_VOLTAGE_LEVEL(TEST_VOLTAGE_LEVEL), .WAIT_MODE(WAIT_MODE),
      .STOP_MODE(STOP_MODE), .HIGH_VOLTAGE_ENABLE(HIGH_VOLTAGE_ENABLE),
      .CHARGE_PUMP_ON(CHARGE_PUMP_ON), .ARRAY_STANDBY(ARRAY_STANDBY));

   always #12.5 MCLK = ~MCLK;

   // ----------------------------------------------------------------
   // Checking and bus tasks
   // ----------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge MCLK);
   endtask

   task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] r);
      bit aw_ok;
      bit w_ok;
      int n;
      aw_ok = 0;
      w_ok = 0;
      n = 0;
      q_b.push_back(r);
      AWADDR <= a;
      WDATA <= d;
      WSTRB <= s;
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      BREADY <= 1'b1;
      while (!(aw_ok && w_ok) && n < 50) begin
         @(posedge MCLK);
         n++;
         if (!aw_ok && AWREADY === 1'b1) begin
            aw_ok = 1;
            AWVALID <= 1'b0;
         end
         if (!w_ok && WREADY === 1'b1) begin
            w_ok = 1;
            WVALID <= 1'b0;
         end
      end
      while (BVALID !== 1'b1 && n < 50) begin
         @(posedge MCLK);
         n++;
      end
      chk("write_done", 32'(n < 50), 32'h0000_0001);
      BREADY <= 1'b0;
      @(posedge MCLK);
   endtask

   task automatic rd(input logic [15:0] a, input logic [31:0] e, input logic [31:0] m,
                     input logic [1:0] r);
      int n;
      n = 0;
      q_r.push_back({r, m, e});
      ARADDR <= a;
      ARVALID <= 1'b1;
      RREADY <= 1'b1;
      do begin
         @(posedge MCLK);
         n++;
      end while (ARREADY !== 1'b1 && n < 50);
      ARVALID <= 1'b0;
      while (RVALID !== 1'b1 && n < 50) begin
         @(posedge MCLK);
         n++;
      end
      chk("read_done", 32'(n < 50), 32'h0000_0001);
      RREADY <= 1'b0;
      @(posedge MCLK);
   endtask

   // Responses are paired with the oldest expectation in arrival order
   always @(posedge MCLK) begin
      logic [65:0] e;
      if (BVALID === 1'b1 && BREADY === 1'b1 && q_b.size() > 0) begin
         chk("bresp", 32'(BRESP), 32'(q_b.pop_front()));
      end
      if (RVALID === 1'b1 && RREADY === 1'b1 && q_r.size() > 0) begin
         e = q_r.pop_front();
         chk("rresp", 32'(RRESP), 32'(e[65:64]));
         chk("rdata", RDATA & e[63:32], e[31:0] & e[63:32]);
      end
   end

   // ----------------------------------------------------------------
   // Flash sequences
   // ----------------------------------------------------------------
   task automatic do_reset();
      SRST <= 1'b1;
      WAIT_MODE <= 1'b0;
      STOP_MODE <= 1'b0;
      tick(2);
      SRST <= 1'b0;
      tick(1);
   endtask

   // Select, read protect byte, target, voltage on: the order software must keep
   task automatic prot_op(input logic [1:0] sel, input logic [7:0] d);
      wr(fbp_pkg::FBP_CTRL_OFS, 32'(sel), 4'hf, OK);
      rd(fbp_pkg::FBP_PROT_OFS, 32'(prot_m), 32'h0000_00ff, OK);
      wr(fbp_pkg::FBP_TGT_OFS, 32'h0000_ff80, 4'hf, OK);
      wr(fbp_pkg::FBP_CTRL_OFS, 32'(sel) | 32'h0000_0008, 4'hf, OK);
      wr(fbp_pkg::FBP_PROT_OFS, 32'(d), 4'h1, OK);
      wr(fbp_pkg::FBP_CTRL_OFS, 32'h0000_0000, 4'hf, OK);
      prot_m = sel[1] ? 8'h00 : (prot_m | d);
   endtask

   // Test voltage lets the protect byte itself be erased and reprogrammed
   task automatic set_prot(input logic [7:0] p);
      TEST_VOLTAGE_LEVEL <= 1'b1;
      prot_op(2'b10, 8'h00);
      prot_op(2'b01, p);
      TEST_VOLTAGE_LEVEL <= 1'b0;
      // Let the drop land before the next scenario drives the pin again
      tick(1);
   endtask

   task automatic try_addr(input logic [15:0] a, input logic [1:0] sel, input bit tv,
                           input bit stop);
      bit op;
      op = tv || !((prot_m[3] && a >= 16'hf000) || (prot_m[2] && a >= 16'he000) ||
                   (prot_m[1] && a >= 16'hc000) || (prot_m[0] && a >= 16'ha000));
      TEST_VOLTAGE_LEVEL <= tv;
      wr(fbp_pkg::FBP_CTRL_OFS, 32'(sel), 4'hf, OK);
      rd(fbp_pkg::FBP_PROT_OFS, 32'(prot_m), 32'h0000_00ff, OK);
      wr(fbp_pkg::FBP_TGT_OFS, 32'(a), 4'hf, OK);
      rd(fbp_pkg::FBP_CTRL_OFS, op ? 32'(sel) : 32'h0, 32'h0000_000b, OK);
      wr(fbp_pkg::FBP_CTRL_OFS, 32'(sel) | 32'h0000_0008, 4'hf, OK);
      chk("hv_enable", 32'(HIGH_VOLTAGE_ENABLE), 32'(op));
      rd(fbp_pkg::FBP_STAT_OFS, {28'h0, tv, 1'b0, op, op}, 32'h0000_000f, OK);
      if (op) begin
         // A locked cell must ignore a live program or erase pulse
         if (!tv && prot_m != 8'h00) begin
            wr(fbp_pkg::FBP_PROT_OFS, 32'h0000_000f, 4'h1, OK);
            rd(fbp_pkg::FBP_PROT_OFS, 32'(prot_m), 32'h0000_00ff, OK);
         end
         STOP_MODE <= stop;
         WAIT_MODE <= !stop;
         tick(2);
         chk("pump_on", 32'(CHARGE_PUMP_ON), 32'h0);
         chk("hv_held", 32'(HIGH_VOLTAGE_ENABLE), 32'h1);
         chk("standby", 32'(ARRAY_STANDBY), 32'h0);
         wr(fbp_pkg::FBP_CTRL_OFS, 32'h0000_0000, 4'hf, OK);
         rd(fbp_pkg::FBP_CTRL_OFS, 32'(sel) | 32'h8, 32'h0000_000b, OK);
         do_reset();
      end else begin
         wr(fbp_pkg::FBP_CTRL_OFS, 32'h0000_0000, 4'hf, OK);
      end
   endtask

   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [15:0] a;
      void'($urandom(32'hefb6));
      tick(3);
      SRST <= 1'b0;
      tick(1);
      rd(fbp_pkg::FBP_PROT_OFS, 32'h0, 32'h0000_00ff, OK);
      rd(fbp_pkg::FBP_STAT_OFS, 32'h0, 32'h0000_000f, OK);
      wr(16'h0010, 32'h0000_0001, 4'hf, fbp_pkg::FBP_RESP_SLVERR);
      rd(16'h0010, 32'h0, 32'h0, fbp_pkg::FBP_RESP_SLVERR);
      wr(fbp_pkg::FBP_CTRL_OFS, 32'h0000_0001, 4'h0, OK);
      rd(fbp_pkg::FBP_CTRL_OFS, 32'h0, 32'h0000_000b, OK);
      wr(fbp_pkg::FBP_CTRL_OFS, 32'h0000_0008, 4'hf, OK);
      chk("hv_no_select", 32'(HIGH_VOLTAGE_ENABLE), 32'h0);
      wr(fbp_pkg::FBP_CTRL_OFS, 32'h0000_0001, 4'hf, OK);
      wr(fbp_pkg::FBP_CTRL_OFS, 32'h0000_0009, 4'hf, OK);
      chk("hv_no_latch", 32'(HIGH_VOLTAGE_ENABLE), 32'h0);
      wr(fbp_pkg::FBP_CTRL_OFS, 32'h0000_0000, 4'hf, OK);
      $display("TEST basic access done");
      for (int i = 0; i < 7; i++) begin
         set_prot(pats[i]);
         for (int j = 0; j < 9; j++) begin
            a = (j == 8) ? 16'($urandom_range(16'hffff, 16'ha000)) : adrs[j];
            try_addr(a, (j % 2 == 1) ? 2'b10 : 2'b01, j == 7, i % 2 == 1);
         end
         $display("TEST protect pattern %h done", pats[i]);
      end
      WAIT_MODE <= 1'b1;
      tick(2);
      chk("wait_standby", 32'(ARRAY_STANDBY), 32'h0);
      rd(fbp_pkg::FBP_PROT_OFS, 32'(prot_m), 32'h0000_00ff, OK);
      WAIT_MODE <= 1'b0;
      STOP_MODE <= 1'b1;
      tick(2);
      chk("stop_standby", 32'(ARRAY_STANDBY), 32'h1);
      rd(fbp_pkg::FBP_STAT_OFS, 32'h0000_0004, 32'h0000_000f, OK);
      STOP_MODE <= 1'b0;
      tick(2);
      chk("standby_left", 32'(ARRAY_STANDBY), 32'h0);
      $display("TEST low power read mode done");
      give_verdict();
   end

   // Whole run is a few thousand cycles; this limit is far beyond it
   initial begin
      #1_000_000;
      mismatches++;
      $display("CHECK FAILED watchdog expected finish seen timeout");
      give_verdict();
   end
endmodule // tb_top
